// >>> rtl/sgc_pkg.sv
// sgc_pkg: constants of the self-calibration gain correction stage
// assumes: shared by the top module, the multiplier and its interface
package sgc_pkg;
    localparam int unsigned SGC_DATA_W    = 24;
    localparam int unsigned SGC_COEF_W    = 24;
    localparam int unsigned SGC_COEF_FRAC = 23;
    localparam int unsigned SGC_PROD_W    = SGC_DATA_W + SGC_COEF_W + 1;
    localparam int unsigned SGC_NUM_GAINS = 8;
    localparam int unsigned SGC_ADDR_W    = 8;
    localparam int unsigned SGC_SEL_W     = 3;
    // register offsets
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X1   = 8'h18;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X2   = 8'h19;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X4   = 8'h1a;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X8   = 8'h1b;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X16  = 8'h1c;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X32  = 8'h1d;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X64  = 8'h1e;
    localparam logic [7:0] SGC_OFS_GAIN_TRIM_X128 = 8'h1f;
    // coefficient after reset: 1.0 in the 1.23 format
    localparam logic [23:0] SGC_COEF_RST  = 24'h800000;
    localparam logic [23:0] SGC_COEF_UNIT = 24'h800000;
    // half an output lsb, added before truncation
    localparam logic [48:0] SGC_ROUND     = 49'h0000000400000;
    localparam logic [23:0] SGC_POS_FS    = 24'h7fffff;
    localparam logic [23:0] SGC_NEG_FS    = 24'h800000;
    // edges from input sample to output valid
    localparam int unsigned SGC_LATENCY   = 3;
endpackage

// >>> rtl/sgc_mul_if.sv
// sgc_mul_if: operands and product between the stage and its multiplier
// assumes: single clock, product returned one edge after operands
`timescale 1ns/1ps
`default_nettype none
interface sgc_mul_if;
    import sgc_pkg::*;
    logic                         op_valid;
    logic signed [SGC_DATA_W-1:0] op_sample;
    logic        [SGC_COEF_W-1:0] op_coef;
    logic                         prod_valid;
    logic signed [SGC_PROD_W-1:0] prod;
    modport stage (output op_valid, output op_sample, output op_coef,
                   input prod_valid, input prod);
    modport mult  (input op_valid, input op_sample, input op_coef,
                   output prod_valid, output prod);
endinterface
`default_nettype wire

// >>> rtl/sgc_mul.sv
// sgc_mul: registered signed sample times unsigned 1.23 coefficient
// assumes: operands stable in the cycle they are flagged valid
`timescale 1ns/1ps
`default_nettype none
module sgc_mul
    import sgc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    sgc_mul_if.mult   m
);
    logic                         valid_d, valid_q;
    logic signed [SGC_PROD_W-1:0] prod_d, prod_q;

    always_comb begin
        valid_d = m.op_valid;
        prod_d  = prod_q;
        if (m.op_valid) begin
            // coefficient zero-extended: always unsigned
            prod_d = SGC_PROD_W'(m.op_sample) *
                     SGC_PROD_W'($signed({1'b0, m.op_coef}));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            prod_q  <= '0;
        end else begin
            valid_q <= valid_d;
            prod_q  <= prod_d;
        end
    end

    assign m.prod_valid = valid_q;
    assign m.prod       = prod_q;
endmodule
`default_nettype wire

// >>> rtl/sgc_top.sv
// sgc_top: self-calibration gain correction with its coefficient bank
// assumes: raw result, offset and gain select come from logic on clk;
// register port and calibration writer are in the same clock domain
//
// Summary of operation
// - scale each result after self offset removal, before system corrections.
// - eight 24-bit coefficients, one per gain; gains 1..32 at 0x18..0x1d.
// - coefficient is fixed point 1.23, msb weight one, lsb two to -23.
// - coefficient unsigned, independent of unipolar/bipolar and coding choice.
// - written value held until next write or an on-demand calibration.
// - scaling reaches just below 2x, correcting gain errors near -50%.
// - corrected gain within 2 lsb of ideal after self-calibration.
// - gains 64 and 128 coefficients sit at 0x1e and 0x1f, same format.
// - self-calibration offset subtracted from raw result in stage 1 of this stage, before scaling.
`timescale 1ns/1ps
`default_nettype none
module sgc_top
    import sgc_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               rst,
    // conversion path
    input  wire logic                               in_valid,
    input  wire logic signed [sgc_pkg::SGC_DATA_W-1:0] in_raw,
    input  wire logic signed [sgc_pkg::SGC_DATA_W-1:0] in_self_offset,
    input  wire logic        [sgc_pkg::SGC_SEL_W-1:0]  in_gain_sel,
    output logic                                    out_valid,
    output logic signed [sgc_pkg::SGC_DATA_W-1:0]  out_data,
    output logic                                    out_sat,
    // register port
    input  wire logic                               reg_wr_en,
    input  wire logic                               reg_rd_en,
    input  wire logic        [sgc_pkg::SGC_ADDR_W-1:0] reg_addr,
    input  wire logic        [sgc_pkg::SGC_COEF_W-1:0] reg_wdata,
    output logic             [sgc_pkg::SGC_COEF_W-1:0] reg_rdata,
    output logic                                    reg_rd_valid,
    // on-demand calibration result
    input  wire logic                               cal_wr_en,
    input  wire logic        [sgc_pkg::SGC_SEL_W-1:0]  cal_gain_sel,
    input  wire logic        [sgc_pkg::SGC_COEF_W-1:0] cal_value
);
    import sgc_pkg::*;

    // saturate a 26-bit signed value to 24 bits, flag when clipped
    function automatic logic [SGC_DATA_W:0] sat24(
        input logic signed [SGC_DATA_W+1:0] v);
        logic [SGC_DATA_W:0] r;
        r = {1'b0, v[SGC_DATA_W-1:0]};
        if (v > $signed({3'b000, SGC_POS_FS[SGC_DATA_W-2:0]})) begin
            r = {1'b1, SGC_POS_FS};
        end else if (v < $signed({3'b111, SGC_NEG_FS[SGC_DATA_W-2:0]})) begin
            r = {1'b1, SGC_NEG_FS};
        end
        return r;
    endfunction

    // register offset to bank index, valid flag in the msb
    function automatic logic [SGC_SEL_W:0] trim_index(
        input logic [SGC_ADDR_W-1:0] a);
        logic [SGC_ADDR_W-1:0] rel;
        rel = a - SGC_OFS_GAIN_TRIM_X1;
        if (a >= SGC_OFS_GAIN_TRIM_X1 && a <= SGC_OFS_GAIN_TRIM_X128) begin
            return {1'b1, rel[SGC_SEL_W-1:0]};
        end
        return '0;
    endfunction

    sgc_mul_if mi ();

    sgc_mul sgc_mul_i (
        .clk (clk),
        .rst (rst),
        .m   (mi.mult)
    );

    // coefficient bank and register port
    logic [SGC_NUM_GAINS-1:0][SGC_COEF_W-1:0] coef_d, coef_q;
    logic [SGC_COEF_W-1:0]                    rdata_d, rdata_q;
    logic                                     rd_valid_d, rd_valid_q;
    logic [SGC_SEL_W:0]                       wr_hit, rd_hit;

    always_comb begin
        wr_hit     = trim_index(reg_addr);
        rd_hit     = wr_hit;
        coef_d     = coef_q;
        rdata_d    = rdata_q;
        rd_valid_d = reg_rd_en;
        if (reg_wr_en && wr_hit[SGC_SEL_W]) begin
            coef_d[wr_hit[SGC_SEL_W-1:0]] = reg_wdata;
        end
        if (cal_wr_en) begin
            // measured value wins over a same-cycle software write
            coef_d[cal_gain_sel] = cal_value;
        end
        if (reg_rd_en) begin
            rdata_d = '0;
            if (rd_hit[SGC_SEL_W]) begin
                rdata_d = coef_q[rd_hit[SGC_SEL_W-1:0]];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coef_q     <= {SGC_NUM_GAINS{SGC_COEF_RST}};
            rdata_q    <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            coef_q     <= coef_d;
            rdata_q    <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // stage 1: offset removal and coefficient pick
    logic                          s1_valid_d, s1_valid_q;
    logic signed [SGC_DATA_W-1:0]  s1_diff_d, s1_diff_q;
    logic        [SGC_COEF_W-1:0]  s1_coef_d, s1_coef_q;
    logic signed [SGC_DATA_W+1:0]  diff_full;
    logic        [SGC_DATA_W:0]    diff_sat;

    always_comb begin
        diff_full  = (SGC_DATA_W+2)'(in_raw) -
                     (SGC_DATA_W+2)'(in_self_offset);
        diff_sat   = sat24(diff_full);
        s1_valid_d = in_valid;
        s1_diff_d  = s1_diff_q;
        s1_coef_d  = s1_coef_q;
        if (in_valid) begin
            s1_diff_d = diff_sat[SGC_DATA_W-1:0];
            s1_coef_d = coef_q[in_gain_sel];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_diff_q  <= '0;
            s1_coef_q  <= SGC_COEF_RST;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_diff_q  <= s1_diff_d;
            s1_coef_q  <= s1_coef_d;
        end
    end

    // offset-corrected sample scaled next, system stages come after
    assign mi.op_valid  = s1_valid_q;
    assign mi.op_sample = s1_diff_q;
    assign mi.op_coef   = s1_coef_q;

    // clip in the offset stage carried along with its sample
    logic                          diff_sat_d, diff_sat_q, diff_sat2_q;

    always_comb begin
        diff_sat_d = in_valid & diff_sat[SGC_DATA_W];
    end

    // stage 3: round to nearest, drop 23 fraction bits, clip
    logic                          out_valid_d, out_valid_q;
    logic signed [SGC_DATA_W-1:0]  out_data_d, out_data_q;
    logic                          out_sat_d, out_sat_q;
    logic signed [SGC_PROD_W-1:0]  prod_rnd;
    logic        [SGC_DATA_W:0]    prod_sat;

    always_comb begin
        prod_rnd    = mi.prod + $signed(SGC_ROUND);
        prod_sat    = sat24(prod_rnd[SGC_PROD_W-1:SGC_COEF_FRAC]);
        out_valid_d = mi.prod_valid;
        out_data_d  = out_data_q;
        out_sat_d   = out_sat_q;
        if (mi.prod_valid) begin
            out_data_d = prod_sat[SGC_DATA_W-1:0];
            out_sat_d  = prod_sat[SGC_DATA_W] | diff_sat_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
            out_sat_q   <= 1'b0;
            diff_sat2_q <= 1'b0;
            diff_sat_q  <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            out_data_q  <= out_data_d;
            out_sat_q   <= out_sat_d;
            diff_sat2_q <= diff_sat_d;
            diff_sat_q  <= diff_sat2_q;
        end
    end

    assign out_valid    = out_valid_q;
    assign out_data     = out_data_q;
    assign out_sat      = out_sat_q;
    assign reg_rdata    = rdata_q;
    assign reg_rd_valid = rd_valid_q;

    // checks
    property p_latency;
        @(posedge clk) disable iff (rst)
        in_valid |-> ##3 out_valid;
    endproperty
    a_latency: assert property (p_latency)
        else $error("result not out three edges after sample");

    property p_pick;
        @(posedge clk) disable iff (rst)
        in_valid && !reg_wr_en && !cal_wr_en
            |=> s1_coef_q == coef_q[$past(in_gain_sel)];
    endproperty
    a_pick: assert property (p_pick)
        else $error("coefficient of wrong gain picked");

    property p_unity;
        @(posedge clk) disable iff (rst)
        s1_valid_q && s1_coef_q == SGC_COEF_UNIT
            |-> ##2 out_data == $past(s1_diff_q, 2);
    endproperty
    a_unity: assert property (p_unity)
        else $error("unit coefficient does not pass sample through");

    property p_sign;
        @(posedge clk) disable iff (rst)
        s1_valid_q && s1_diff_q[SGC_DATA_W-1]
            |-> ##2 !out_data[SGC_DATA_W-1] == (out_data == '0);
    endproperty
    a_sign: assert property (p_sign)
        else $error("negative sample changed sign");

    property p_sw_write;
        @(posedge clk) disable iff (rst)
        reg_wr_en && wr_hit[SGC_SEL_W] && !cal_wr_en
            |=> coef_q[$past(wr_hit[SGC_SEL_W-1:0])] == $past(reg_wdata);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("register write not stored");

    property p_hold;
        @(posedge clk) disable iff (rst)
        !reg_wr_en && !cal_wr_en |=> $stable(coef_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("coefficient changed without a write");

    property p_cal;
        @(posedge clk) disable iff (rst)
        cal_wr_en |=> coef_q[$past(cal_gain_sel)] == $past(cal_value);
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration value not stored");

    property p_readback;
        @(posedge clk) disable iff (rst)
        reg_rd_en && reg_addr == SGC_OFS_GAIN_TRIM_X128
            |=> reg_rd_valid && reg_rdata == $past(coef_q[7]);
    endproperty
    a_readback: assert property (p_readback)
        else $error("gain 128 coefficient not read back");

    property p_offset;
        @(posedge clk) disable iff (rst)
        in_valid && !diff_sat[SGC_DATA_W]
            |=> s1_diff_q == $past(diff_full[SGC_DATA_W-1:0]);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not removed before scaling");

    property p_clip;
        @(posedge clk) disable iff (rst)
        out_valid && out_sat && $past(mi.prod_valid) &&
        $past(prod_sat[SGC_DATA_W])
            |-> out_data == $signed(SGC_POS_FS) ||
                out_data == $signed(SGC_NEG_FS);
    endproperty
    a_clip: assert property (p_clip)
        else $error("overflow wrapped instead of clipping");

    property p_rd_valid;
        @(posedge clk) disable iff (rst)
        reg_rd_valid == $past(reg_rd_en);
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read answer not one edge after request");

    property p_unmapped;
        @(posedge clk) disable iff (rst)
        reg_rd_en && !rd_hit[SGC_SEL_W] |=> reg_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero data");

    property p_rd_hold;
        @(posedge clk) disable iff (rst)
        !reg_rd_en |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");

    property p_no_extra;
        @(posedge clk) disable iff (rst)
        !in_valid |-> ##3 !out_valid;
    endproperty
    a_no_extra: assert property (p_no_extra)
        else $error("result flagged without a sample");
endmodule
`default_nettype wire

// >>> verification/sgc_top_bench.sv
// sgc_top_bench: self-checking bench for the gain correction stage
// assumes: sgc_pkg and the rtl files compiled first, single 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module sgc_top_bench;
    import sgc_pkg::*;

    logic                         clk;
    logic                         rst;
    logic                         in_valid;
    logic signed [SGC_DATA_W-1:0] in_raw;
    logic signed [SGC_DATA_W-1:0] in_self_offset;
    logic        [SGC_SEL_W-1:0]  in_gain_sel;
    logic                         out_valid;
    logic signed [SGC_DATA_W-1:0] out_data;
    logic                         out_sat;
    logic                         reg_wr_en;
    logic                         reg_rd_en;
    logic        [SGC_ADDR_W-1:0] reg_addr;
    logic        [SGC_COEF_W-1:0] reg_wdata;
    logic        [SGC_COEF_W-1:0] reg_rdata;
    logic                         reg_rd_valid;
    logic                         cal_wr_en;
    logic        [SGC_SEL_W-1:0]  cal_gain_sel;
    logic        [SGC_COEF_W-1:0] cal_value;
    logic        [23:0]           exp_coef [8];
    int                           n_mismatch;
    int                           samples_checked;

    sgc_top sgc_top_i (.clk(clk), .rst(rst), .in_valid(in_valid),
        .in_raw(in_raw), .in_self_offset(in_self_offset),
        .in_gain_sel(in_gain_sel), .out_valid(out_valid),
        .out_data(out_data), .out_sat(out_sat), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .cal_wr_en(cal_wr_en),
        .cal_gain_sel(cal_gain_sel), .cal_value(cal_value));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // saturate offset difference and product, round half up
    function automatic logic [24:0] model(longint raw, longint off,
                                          longint coef);
        longint d;
        longint p;
        logic   s;
        s = 1'b0;
        d = raw - off;
        if (d > 8388607) begin
            d = 8388607;
            s = 1'b1;
        end else if (d < -8388608) begin
            d = -8388608;
            s = 1'b1;
        end
        p = (d * coef + 4194304) >>> 23;
        if (p > 8388607) begin
            p = 8388607;
            s = 1'b1;
        end else if (p < -8388608) begin
            p = -8388608;
            s = 1'b1;
        end
        return {s, p[23:0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        chk({23'h0, reg_rd_valid}, 24'h000001);
        chk(reg_rdata, e);
    endtask

    // one sample through the path, exact latency of three edges
    task automatic smp(input int raw, input int off, input int sel);
        logic [24:0] e;
        e = model(raw, off, longint'(exp_coef[sel]));
        @(posedge clk);
        in_valid       <= 1'b1;
        in_raw         <= raw[23:0];
        in_self_offset <= off[23:0];
        in_gain_sel    <= sel[2:0];
        @(posedge clk);
        in_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk({23'h0, out_valid}, 24'h000000);
        @(posedge clk);
        #1;
        chk({23'h0, out_valid}, 24'h000001);
        chk(out_data, e[23:0]);
        chk({23'h0, out_sat}, {23'h0, e[24]});
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        int raws [8];
        int offs [8];
        logic [23:0] cvals [8];
        raws  = '{3, 6000000, -7000000, 1234567, 8000000, -8388608,
                  -333333, -5};
        offs  = '{0, 0, 0, -100, -1000000, 1, 4321, 0};
        cvals = '{24'h400000, 24'hffffff, 24'hc00000, 24'h000001,
                  24'h800001, 24'h3fffff, 24'h9abcde, 24'hfedcba};
        n_mismatch      = 0;
        samples_checked = 0;
        rst = 1'b1;
        in_valid = 1'b0;
        in_raw = '0;
        in_self_offset = '0;
        in_gain_sel = '0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        cal_wr_en = 1'b0;
        cal_gain_sel = '0;
        cal_value = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(8'h18 + i[7:0], SGC_COEF_RST);
        end
        rd(8'h17, 24'h000000);
        for (int i = 0; i < 8; i++) begin
            wr(8'h18 + i[7:0], cvals[i]);
            exp_coef[i] = cvals[i];
        end
        wr(8'h20, 24'hffffff);
        rd(8'h20, 24'h000000);
        for (int i = 0; i < 8; i++) begin
            rd(8'h18 + i[7:0], exp_coef[i]);
        end
        @(posedge clk);
        cal_wr_en    <= 1'b1;
        cal_gain_sel <= 3'h3;
        cal_value    <= 24'hc00000;
        @(posedge clk);
        cal_wr_en    <= 1'b0;
        exp_coef[3] = 24'hc00000;
        rd(8'h1b, 24'hc00000);
        @(posedge clk);
        reg_wr_en    <= 1'b1;
        reg_addr     <= 8'h1d;
        reg_wdata    <= 24'h111111;
        cal_wr_en    <= 1'b1;
        cal_gain_sel <= 3'h5;
        cal_value    <= 24'h222222;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        cal_wr_en <= 1'b0;
        exp_coef[5] = 24'h222222;
        rd(8'h1d, 24'h222222);
        for (int i = 0; i < 8; i++) begin
            smp(raws[i], offs[i], i);
        end
        smp(-8388608, 0, 1);
        // second reset in mid-run: bank back to 1.0
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({23'h0, out_valid}, 24'h000000);
        chk(out_data, 24'h000000);
        chk({23'h0, reg_rd_valid}, 24'h000000);
        for (int i = 0; i < 8; i++) begin
            exp_coef[i] = SGC_COEF_RST;
        end
        rd(8'h1f, SGC_COEF_RST);
        smp(1000, 0, 0);
        end_sim();
    end
endmodule
`default_nettype wire
